// *** pbc_top.sv ***
`default_nettype none

module pbc_top #(
    parameter int tick_cycles = pbc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control line from the host
    input wire logic dim_ctrl_line,
    // Brightness state
    output logic [5:0] level,
    output logic count_up,
    output logic presetting,
    // Driver control
    output logic drivers_on,
    output logic powered
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic line_q;
        pbc_pkg::pbc_mode_type mode;
        logic [7:0] presc;
        logic [10:0] phase_us;
        logic [5:0] level;
        logic count_up;
        logic preset;
        logic seen_edge;
        logic drivers_on;
        logic powered;
    } pbc_state_type;

    pbc_state_type st;
    pbc_state_type next_st;
    logic fall_evt;
    logic rise_evt;
    logic tick;
    logic step;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        step = 1'b0;
        next_st.sync1 = dim_ctrl_line;
        next_st.sync2 = st.sync1;
        next_st.line_q = st.sync2;
        fall_evt = st.line_q & ~st.sync2;
        rise_evt = ~st.line_q & st.sync2;
        tick = (st.presc == 8'(tick_cycles - 1));

        // Phase timer restarts on every edge and saturates when idle.
        if (fall_evt || rise_evt)
        begin
            next_st.presc = 8'h00;
            next_st.phase_us = 11'h000;
        end
        else
        begin
            next_st.presc = tick ? 8'h00 : st.presc + 8'h01;
            if (tick && st.phase_us != pbc_pkg::PHASE_SAT)
            begin
                next_st.phase_us = st.phase_us + 11'h001;
            end
        end

        case (st.mode)
            pbc_pkg::mode_off:
            begin
                next_st.level = pbc_pkg::LEVEL_DEFAULT;
                next_st.count_up = 1'b0;
                next_st.preset = 1'b0;
                next_st.seen_edge = 1'b0;
                next_st.drivers_on = 1'b0;
                if (st.sync2)
                begin
                    next_st.mode = pbc_pkg::mode_setup;
                end
            end
            pbc_pkg::mode_setup:
            begin
                // Direction pulses are never classified here.
                next_st.count_up = 1'b0;
                if (fall_evt)
                begin
                    next_st.seen_edge = 1'b1;
                    if (st.preset)
                    begin
                        step = 1'b1;
                    end
                    else if (!st.seen_edge && st.phase_us >= pbc_pkg::PRESET_OPEN_US
                             && st.phase_us <= pbc_pkg::PRESET_CLOSE_US)
                    begin
                        next_st.preset = 1'b1;
                        step = 1'b1;
                    end
                end
                if (st.sync2 && !rise_evt && st.phase_us >= pbc_pkg::STARTUP_US)
                begin
                    next_st.mode = pbc_pkg::mode_run;
                    next_st.drivers_on = 1'b1;
                    next_st.preset = 1'b0;
                end
                else if (!st.sync2 && st.phase_us >= pbc_pkg::SHUTDOWN_US)
                begin
                    next_st.mode = pbc_pkg::mode_off;
                end
            end
            pbc_pkg::mode_run:
            begin
                if (rise_evt)
                begin
                    if (st.phase_us >= pbc_pkg::UP_MIN_US
                        && st.phase_us <= pbc_pkg::UP_MAX_US)
                    begin
                        next_st.count_up = 1'b1;
                    end
                    else if (st.phase_us >= pbc_pkg::DOWN_MIN_US
                             && st.phase_us <= pbc_pkg::DOWN_MAX_US)
                    begin
                        next_st.count_up = 1'b0;
                    end
                end
                // An edge after a long high only marks the start of a burst.
                if (fall_evt && st.phase_us <= pbc_pkg::STEP_TIME_MAX_US)
                begin
                    step = 1'b1;
                end
                if (!st.sync2 && st.phase_us >= pbc_pkg::SHUTDOWN_US)
                begin
                    next_st.mode = pbc_pkg::mode_off;
                    next_st.drivers_on = 1'b0;
                    next_st.level = pbc_pkg::LEVEL_DEFAULT;
                    next_st.count_up = 1'b0;
                end
            end
            default:
            begin
                next_st.mode = pbc_pkg::mode_off;
            end
        endcase

        // Powered is registered so the output does not come from a decoder.
        next_st.powered = (next_st.mode != pbc_pkg::mode_off);

        // Counter update wraps at both ends.
        if (step)
        begin
            if (st.count_up)
            begin
                next_st.level = (st.level == pbc_pkg::LEVEL_MAX) ? pbc_pkg::LEVEL_MIN
                                : st.level + 6'h01;
            end
            else
            begin
                next_st.level = (st.level == pbc_pkg::LEVEL_MIN) ? pbc_pkg::LEVEL_MAX
                                : st.level - 6'h01;
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st.sync1 <= 1'b0;
            st.sync2 <= 1'b0;
            st.line_q <= 1'b0;
            st.mode <= pbc_pkg::mode_off;
            st.presc <= 8'h00;
            st.phase_us <= 11'h000;
            st.level <= pbc_pkg::LEVEL_DEFAULT;
            st.count_up <= 1'b0;
            st.preset <= 1'b0;
            st.seen_edge <= 1'b0;
            st.drivers_on <= 1'b0;
            st.powered <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign level = st.level;
    assign count_up = st.count_up;
    assign presetting = st.preset;
    assign drivers_on = st.drivers_on;
    assign powered = st.powered;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    level_in_range_a: assert property (st.level <= pbc_pkg::LEVEL_MAX)
    else $error("Level left the range 0 to 48.");

    wrap_down_a: assert property (
        step && !st.count_up && st.level == pbc_pkg::LEVEL_MIN
        |=> st.level == pbc_pkg::LEVEL_MAX)
    else $error("Down step from level 0 did not wrap to 48.");

    wrap_up_a: assert property (
        step && st.count_up && st.level == pbc_pkg::LEVEL_MAX
        |=> st.level == pbc_pkg::LEVEL_MIN)
    else $error("Up step from level 48 did not wrap to 0.");

    down_band_a: assert property (
        st.mode == pbc_pkg::mode_run && rise_evt
        && st.phase_us >= pbc_pkg::DOWN_MIN_US && st.phase_us <= pbc_pkg::DOWN_MAX_US
        |=> !st.count_up)
    else $error("Down direction pulse not taken.");

    up_band_a: assert property (
        st.mode == pbc_pkg::mode_run && rise_evt
        && st.phase_us >= pbc_pkg::UP_MIN_US && st.phase_us <= pbc_pkg::UP_MAX_US
        |=> st.count_up)
    else $error("Up direction pulse not taken.");

    startup_wait_a: assert property (
        $rose(st.drivers_on) |-> $past(st.phase_us) >= pbc_pkg::STARTUP_US
        && $past(st.sync2))
    else $error("Drivers started before the line was high long enough.");

    preset_first_a: assert property (
        st.mode == pbc_pkg::mode_setup && fall_evt && !st.seen_edge
        && st.phase_us >= pbc_pkg::PRESET_OPEN_US
        && st.phase_us <= pbc_pkg::PRESET_CLOSE_US
        |=> st.preset && st.level == $past(st.level) - 6'h01)
    else $error("First preset edge did not step the level down.");

    preset_step_a: assert property (
        st.mode == pbc_pkg::mode_setup && st.preset && fall_evt
        |=> st.level == (($past(st.level) == pbc_pkg::LEVEL_MIN) ? pbc_pkg::LEVEL_MAX
                         : $past(st.level) - 6'h01))
    else $error("Preset edge did not lower the start level by one.");

    dir_keep_a: assert property (
        st.mode == pbc_pkg::mode_run && rise_evt
        && !(st.phase_us >= pbc_pkg::UP_MIN_US && st.phase_us <= pbc_pkg::UP_MAX_US)
        && !(st.phase_us >= pbc_pkg::DOWN_MIN_US && st.phase_us <= pbc_pkg::DOWN_MAX_US)
        |=> $stable(st.count_up))
    else $error("Low outside both bands changed the direction.");

    off_state_a: assert property (
        st.mode == pbc_pkg::mode_off |-> !st.drivers_on && !st.powered && !st.count_up
        && st.level == pbc_pkg::LEVEL_DEFAULT)
    else $error("Shut-down block kept its level, direction or drivers.");

    preset_down_a: assert property (
        st.preset |-> !st.count_up && st.mode == pbc_pkg::mode_setup)
    else $error("Direction changed while presetting.");

    shutdown_clear_a: assert property (
        st.mode == pbc_pkg::mode_run && !st.sync2
        && st.phase_us >= pbc_pkg::SHUTDOWN_US
        |=> !st.drivers_on && !st.count_up && st.level == pbc_pkg::LEVEL_DEFAULT)
    else $error("Long low did not shut the block down.");

    ignore_first_a: assert property (
        st.mode == pbc_pkg::mode_run && fall_evt
        && st.phase_us > pbc_pkg::STEP_TIME_MAX_US
        |=> $stable(st.level))
    else $error("Edge after a long high changed the level.");

    missed_window_a: assert property (
        st.mode == pbc_pkg::mode_setup && fall_evt && !st.seen_edge
        && st.phase_us > pbc_pkg::PRESET_CLOSE_US
        |=> !st.preset && $stable(st.level))
    else $error("Late first edge was taken as a preset.");

    reset_state_a: assert property (
        $fell(rst) |-> st.level == pbc_pkg::LEVEL_DEFAULT && !st.count_up
        && !st.drivers_on)
    else $error("Reset state is not level 48 counting down.");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    preset_seen_c: cover property ($fell(st.preset) && $rose(st.drivers_on));

    wrap_down_c: cover property (step && !st.count_up && st.level == pbc_pkg::LEVEL_MIN);

    one_step_up_c: cover property ($rose(st.count_up) ##[1:1000] step);

    shutdown_c: cover property (st.mode == pbc_pkg::mode_run
                                ##1 st.mode == pbc_pkg::mode_off);

endmodule // pbc_top

`default_nettype wire

// *** pbc_pkg.sv ***
// Notes on behaviour
// - Brightness lives in an up/down counter with 49 states, level 0 to 48.
// - Stepping down from level 0 wraps the counter to level 48.
// - Stepping up from level 48 wraps the counter to level 0.
// - Low of 420-500 us then edge within 2-32 us lowers level by one.
// - Low of 100-160 us then edge within 2-32 us raises level by one.
// - Drivers stay off until the line has been high 140 us after power-on.
// - A first edge outside the preset window leaves the default level 48.
// - In the preset window the very first edge counts as a step.
// - While presetting, direction stays down and direction pulses are ignored.
// - Presetting can give any start level 0 through 48 before drivers start.
// - Each falling edge while presetting lowers the start level by one.
// - Low for 1260 us or more shuts down, returning level to 48 and direction to down.
// - Once running, an edge after more than 32 us of high is ignored.
// - After power-on the direction is down and the level is 48.
`default_nettype none

package pbc_pkg;

    // ----------------------------------------
    // Timebase
    // ----------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;

    // ----------------------------------------
    // Levels
    // ----------------------------------------
    localparam logic [5:0] LEVEL_MIN = 6'h00;
    localparam logic [5:0] LEVEL_MAX = 6'h30;
    localparam logic [5:0] LEVEL_DEFAULT = 6'h30;

    // ----------------------------------------
    // Phase times in microseconds
    // ----------------------------------------
    localparam logic [10:0] STEP_TIME_MAX_US = 11'h020;
    localparam logic [10:0] PRESET_OPEN_US = 11'h005;
    localparam logic [10:0] PRESET_CLOSE_US = 11'h04b;
    localparam logic [10:0] STARTUP_US = 11'h08c;
    localparam logic [10:0] UP_MIN_US = 11'h064;
    localparam logic [10:0] UP_MAX_US = 11'h0a0;
    localparam logic [10:0] DOWN_MIN_US = 11'h1a4;
    localparam logic [10:0] DOWN_MAX_US = 11'h1f4;
    localparam logic [10:0] SHUTDOWN_US = 11'h4ec;
    localparam logic [10:0] PHASE_SAT = 11'h7ff;

    // ----------------------------------------
    // Operating modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        mode_off,
        mode_setup,
        mode_run
    } pbc_mode_type;

endpackage

`default_nettype wire

// *** pbc_host.sv ***
`default_nettype none

module pbc_host #(
    parameter int tick_cycles = 4
) (
    // Clock
    input wire logic clk,
    // Control line towards the block
    output logic dim_ctrl_line
);
    timeunit 1ns;
    timeprecision 100ps;

    initial dim_ctrl_line = 1'b0;

    // ----------------------------------------
    // Line phases
    // ----------------------------------------
    // Holds the line at one level for a whole number of ticks.
    task automatic phase(input logic val, input int ticks);
        @(posedge clk);
        #1;
        dim_ctrl_line = val;
        repeat (ticks * tick_cycles - 1) @(posedge clk);
    endtask

    // Short phases keep at least two ticks of margin inside the band for timing jitter.
    function automatic int short_t();
        return $urandom_range(28, 4);
    endfunction

    // ----------------------------------------
    // Host sequences
    // ----------------------------------------
    task automatic preset(input int n);
        phase(1'b1, $urandom_range(70, 8));
        repeat (n)
        begin
            phase(1'b0, short_t());
            phase(1'b1, short_t());
        end
        phase(1'b1, 150);
    endtask

    task automatic step(input logic up);
        phase(1'b0, up ? $urandom_range(155, 105) : $urandom_range(495, 425));
        phase(1'b1, short_t());
        phase(1'b0, short_t());
        phase(1'b1, 150);
    endtask

    // The first edge follows a long high phase, so the block must ignore it.
    task automatic burst(input int k);
        repeat (k)
        begin
            phase(1'b0, short_t());
            phase(1'b1, short_t());
        end
        phase(1'b1, 150);
    endtask

    task automatic shutdown();
        phase(1'b0, 1300);
    endtask

    // Starts up with a first edge well past the preset window.
    task automatic late_start();
        phase(1'b1, 100);
        burst(2);
    endtask
endmodule // pbc_host

`default_nettype wire

// *** tb_pulse_brightness_counter.sv ***
`default_nettype none

module tb_pulse_brightness_counter;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int tick_cycles = 4;

    logic clk;
    logic rst;
    wire logic dim_ctrl_line;
    logic [5:0] level;
    logic count_up;
    logic presetting;
    logic drivers_on;
    logic powered;
    int failures;
    int total_checks;
    int n;
    logic up;
    logic [5:0] want;

    pbc_top #(.tick_cycles(tick_cycles)) pbc_top_i (
        .clk(clk),
        .rst(rst),
        .dim_ctrl_line(dim_ctrl_line),
        .level(level),
        .count_up(count_up),
        .presetting(presetting),
        .drivers_on(drivers_on),
        .powered(powered)
    );

    pbc_host #(.tick_cycles(tick_cycles)) pbc_host_i (
        .clk(clk),
        .dim_ctrl_line(dim_ctrl_line)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check_state(input logic [5:0] lv, input logic u, input logic on,
                               input logic pw);
        #1;
        check(level, lv);
        check({5'h00, presetting}, 6'h00);
        check({5'h00, count_up}, {5'h00, u});
        check({5'h00, drivers_on}, {5'h00, on});
        check({5'h00, powered}, {5'h00, pw});
    endtask

    function automatic logic [5:0] stepped(input logic [5:0] lv, input logic u);
        if (u)
            return (lv == pbc_pkg::LEVEL_MAX) ? pbc_pkg::LEVEL_MIN : lv + 6'h01;
        return (lv == pbc_pkg::LEVEL_MIN) ? pbc_pkg::LEVEL_MAX : lv - 6'h01;
    endfunction

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        failures = 0;
        total_checks = 0;
        rst = 1'b1;
        n = $urandom(34);
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        check_state(6'h30, 1'b0, 1'b0, 1'b0);
        pbc_host_i.preset(48);
        check_state(6'h00, 1'b0, 1'b1, 1'b1);
        pbc_host_i.shutdown();
        check_state(6'h30, 1'b0, 1'b0, 1'b0);
        n = $urandom_range(47, 1);
        fork
            pbc_host_i.preset(n);
            begin
                @(negedge dim_ctrl_line);
                repeat (6) @(posedge clk);
                #1;
                check({5'h00, presetting}, 6'h01);
                check(level, 6'h2f);
            end
        join
        check_state(6'h30 - 6'(n), 1'b0, 1'b1, 1'b1);
        pbc_host_i.shutdown();
        pbc_host_i.late_start();
        want = 6'h30;
        check_state(want, 1'b0, 1'b1, 1'b1);
        pbc_host_i.step(1'b1);
        want = stepped(want, 1'b1);
        check_state(want, 1'b1, 1'b1, 1'b1);
        pbc_host_i.step(1'b0);
        want = stepped(want, 1'b0);
        check_state(want, 1'b0, 1'b1, 1'b1);
        repeat (6)
        begin
            up = 1'($urandom_range(1, 0));
            pbc_host_i.step(up);
            want = stepped(want, up);
            check_state(want, up, 1'b1, 1'b1);
        end
        pbc_host_i.burst(3);
        want = stepped(stepped(want, up), up);
        check_state(want, up, 1'b1, 1'b1);
        summarize();
    end

    // Cuts a hang short at 90000 cycles, more than twice the typical run length of about 39000 cycles.
    initial
    begin
        repeat (90000) @(posedge clk);
        failures++;
        $display("BAD %0t: watchdog expired", $time);
        summarize();
    end
endmodule // tb_pulse_brightness_counter

`default_nettype wire
